// >>> core/src_defs.svh
// Register map, reset values and timing figures of the speed reference conditioner
`ifndef SRC_DEFS_SVH
`define SRC_DEFS_SVH

// Register byte offsets on the Avalon-MM slave
`define SRC_OFS_ACCEL     8'h00
`define SRC_OFS_DECEL     8'h04
`define SRC_OFS_FILT_TC   8'h08
`define SRC_OFS_CLAMP_LVL 8'h0c
`define SRC_OFS_OFFSET    8'h10
`define SRC_OFS_CONFIG    8'h14
`define SRC_OFS_WPROT     8'h18
`define SRC_OFS_PGAIN1    8'h1c
`define SRC_OFS_PGAIN2    8'h20
`define SRC_OFS_IN_GAIN   8'h24
`define SRC_OFS_STATUS    8'h28
`define SRC_OFS_SPEED     8'h2c
`define SRC_OFS_CMD       8'h30

// Reset and factory values
`define SRC_RST_ACCEL     16'h0000
`define SRC_RST_DECEL     16'h0000
`define SRC_RST_FILT_TC   16'h0028
`define SRC_RST_CLAMP_LVL 16'h000a
`define SRC_RST_PGAIN     16'h0100
`define SRC_RST_IN_GAIN   16'h0100
`define SRC_RST_METHOD    4'h0
`define SRC_WPROT_PERMIT  16'h0000

// Config and command field positions
`define SRC_CFG_ALLOC_BIT 4
`define SRC_METHOD_CLAMP  4'ha
`define SRC_CMD_INIT      0
`define SRC_CMD_ENTER     1
`define SRC_CMD_UP        2
`define SRC_CMD_DOWN      3
`define SRC_CMD_SET       4
`define SRC_CMD_EXIT      5

// Timing figures
`define SRC_CLK_NS        4
`define SRC_SAMPLE_NS     10000
`define SRC_SAMPLE_CYC    (`SRC_SAMPLE_NS / `SRC_CLK_NS)
`define SRC_MS_SAMPLES    100
`define SRC_FLASH_MS      1000
`define SRC_FLASH_CYC     ((`SRC_FLASH_MS * 1000000) / `SRC_CLK_NS)
`define SRC_MAX_RPM       6000

`endif

// >>> core/src_pkg.sv
// Types shared by the speed reference conditioner
package src_pkg;

    // Manual offset utility states
    typedef enum logic [1:0] {
        SRC_OFS_IDLE   = 2'b00,
        SRC_OFS_DENIED = 2'b01,
        SRC_OFS_ADJUST = 2'b10,
        SRC_OFS_DONE   = 2'b11
    } src_ofs_state_e;

endpackage : src_pkg

// >>> core/src_conditioner.sv
// Speed reference conditioner: offset, soft start, lag filter, zero clamp
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "src_defs.svh"

// Behaviour
// - Refuse manual offset unless writes permitted
// - Manual offset only with main power on
// - Write-protected request flashes denial, no entry
// - Parameter init leaves the offset untouched
// - Up/down keys step the live offset (only while servo is on)
// - Set key flashes done, returns to adjust
// - Soft start turns steps into ramps
// - Accel time 0..10000 ms, default 0
// - Decel time in ms, default 0
// - Slope is max speed over set time
// - Both times zero pass command through
// - Lag filter, 0.01 ms units, default 40
// - Clamp request and low command hold position
// - Latch position on entry, drive back
// - Method A uses proportional input as request
// - Deasserted request never enters clamp
// - Hold loop uses first or second gain
// - Clamp level 0..10000 rpm, default 10
module src_conditioner #(
    parameter int FLASH_CYC = `SRC_FLASH_CYC, // Length of a panel flash
    parameter int MAX_RPM   = `SRC_MAX_RPM    // Motor maximum speed
) (
    input  wire logic        clk,            // 250 MHz clock
    input  wire logic        reset,          // Synchronous, active high
    input  wire logic [7:0]  address,        // Avalon byte address
    input  wire logic        read,           // Avalon read
    input  wire logic        write,          // Avalon write
    input  wire logic [31:0] writedata,      // Avalon write data
    output logic      [31:0] readdata,       // Avalon read data
    output logic             waitrequest,    // Avalon stall
    input  wire logic [15:0] speed_cmd_in,   // Digitised command, signed
    input  wire logic [31:0] position_count, // Encoder position, signed
    input  wire logic        gain_switch,    // Second gain set active
    input  wire logic        main_power_on,  // Pin: power stage supplied
    input  wire logic        servo_on,       // Pin: servo enabled
    input  wire logic        proportional_control_input, // Pin
    input  wire logic        clamp_request_input,        // Pin
    output logic      [15:0] speed_ref_out,  // Conditioned speed, signed
    output logic             clamp_active,   // Zero clamp holding
    output logic             adjust_active,  // Manual offset shown
    output logic             denied_flash,   // Write-denied indication
    output logic             done_flash,     // Completion indication
    output logic      [15:0] offset_display  // Offset being shown
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [3:0] pin_raw;  // Raw pins
    logic [3:0] pin_s1;   // First stage, read only by second
    logic [3:0] pin_s2;   // Second stage
    logic [3:0] pin_s3;   // Third stage
    logic [3:0] pin_q;    // Accepted level

    assign pin_raw = {clamp_request_input, proportional_control_input,
                      servo_on, main_power_on};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            // Level accepted only once stages two and three agree
            always_ff @(posedge clk) begin
                if (reset) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_q[gi]  <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_q[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    wire power_q = pin_q[0]; // Main supply on
    wire servo_q = pin_q[1]; // Servo on
    wire prop_q  = pin_q[2]; // Proportional control input
    wire zcl_q   = pin_q[3]; // Clamp request input

    // ==========================================================
    // Register file and bus slave
    // ==========================================================
    logic [15:0] accel_ramp_time;              // Accel time, ms
    logic [15:0] decel_ramp_time;              // Decel time, ms
    logic [15:0] command_filter_time_constant; // Lag, 10 us units
    logic [15:0] clamp_speed_threshold;        // Clamp level, rpm
    logic [15:0] ref_offset;                   // Offset, ADC codes
    logic [3:0]  control_method_select;        // Control method
    logic        input_allocation_mode;        // Input allocation
    logic [15:0] write_protect_setting;        // Write protection
    logic [15:0] position_loop_gain;           // Hold gain, Q8
    logic [15:0] second_position_loop_gain;    // Second hold gain, Q8
    logic [15:0] speed_input_gain;             // ADC to rpm, Q8

    // Access completes on the cycle after waitrequest drops
    wire req    = read | write;
    wire wr_go  = write & ~waitrequest;
    wire [5:0] cmd_bits = writedata[5:0];
    wire cmd_go = wr_go & (address == `SRC_OFS_CMD);
    wire init_go = cmd_go & cmd_bits[`SRC_CMD_INIT];

    // Register write decode
    wire wr_acc = wr_go & (address == `SRC_OFS_ACCEL);
    wire wr_dec = wr_go & (address == `SRC_OFS_DECEL);
    wire wr_ftc = wr_go & (address == `SRC_OFS_FILT_TC);
    wire wr_clv = wr_go & (address == `SRC_OFS_CLAMP_LVL);
    wire wr_cfg = wr_go & (address == `SRC_OFS_CONFIG);
    wire wr_wp  = wr_go & (address == `SRC_OFS_WPROT);
    wire wr_g1  = wr_go & (address == `SRC_OFS_PGAIN1);
    wire wr_g2  = wr_go & (address == `SRC_OFS_PGAIN2);
    wire wr_ig  = wr_go & (address == `SRC_OFS_IN_GAIN);

    // One wait state: waitrequest low for one cycle per request
    always_ff @(posedge clk) begin
        if (reset) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(req & waitrequest);
        end
    end

    // Parameter registers; ramp and lag values act on the next sample, clamp level and gains on the next clock
    always_ff @(posedge clk) begin
        if (reset || init_go) begin
            // Factory restore keeps the offset (separate process)
            accel_ramp_time              <= `SRC_RST_ACCEL;
            decel_ramp_time              <= `SRC_RST_DECEL;
            command_filter_time_constant <= `SRC_RST_FILT_TC;
            clamp_speed_threshold        <= `SRC_RST_CLAMP_LVL;
            control_method_select        <= `SRC_RST_METHOD;
            input_allocation_mode        <= 1'b0;
            position_loop_gain           <= `SRC_RST_PGAIN;
            second_position_loop_gain    <= `SRC_RST_PGAIN;
            speed_input_gain             <= `SRC_RST_IN_GAIN;
        end else begin
            if (wr_acc) accel_ramp_time <= writedata[15:0];
            if (wr_dec) decel_ramp_time <= writedata[15:0];
            if (wr_ftc) command_filter_time_constant <= writedata[15:0];
            if (wr_clv) clamp_speed_threshold <= writedata[15:0];
            if (wr_g1) position_loop_gain <= writedata[15:0];
            if (wr_g2) second_position_loop_gain <= writedata[15:0];
            if (wr_ig) speed_input_gain <= writedata[15:0];
            if (wr_cfg) begin
                control_method_select <= writedata[3:0];
                input_allocation_mode <= writedata[`SRC_CFG_ALLOC_BIT];
            end
        end
    end

    // Write protection is itself not restored by init
    always_ff @(posedge clk) begin
        if (reset) begin
            write_protect_setting <= `SRC_WPROT_PERMIT;
        end else if (wr_wp) begin
            write_protect_setting <= writedata[15:0];
        end
    end

    // ==========================================================
    // Manual offset utility
    // ==========================================================
    src_pkg::src_ofs_state_e ofs_state;      // Utility state
    src_pkg::src_ofs_state_e next_ofs_state; // Next utility state
    logic [27:0] flash_cnt;                  // Flash timer

    wire wp_ok    = (write_protect_setting == `SRC_WPROT_PERMIT);
    wire k_enter  = cmd_go & cmd_bits[`SRC_CMD_ENTER];
    wire k_up     = cmd_go & cmd_bits[`SRC_CMD_UP];
    wire k_down   = cmd_go & cmd_bits[`SRC_CMD_DOWN];
    wire k_set    = cmd_go & cmd_bits[`SRC_CMD_SET];
    wire k_exit   = cmd_go & cmd_bits[`SRC_CMD_EXIT];
    wire flash_end = (flash_cnt == 28'(FLASH_CYC - 1));
    wire in_adj   = (ofs_state == src_pkg::SRC_OFS_ADJUST);
    wire step_ok  = in_adj & servo_q;

    // Next-state choice for the utility
    always_comb begin
        next_ofs_state = ofs_state;
        case (ofs_state)
            src_pkg::SRC_OFS_IDLE: begin
                if (k_enter && !wp_ok) begin
                    next_ofs_state = src_pkg::SRC_OFS_DENIED;
                end else if (k_enter && power_q) begin
                    next_ofs_state = src_pkg::SRC_OFS_ADJUST;
                end
            end
            src_pkg::SRC_OFS_DENIED: begin
                // Flash then fall back without adjusting
                if (flash_end) next_ofs_state = src_pkg::SRC_OFS_IDLE;
            end
            src_pkg::SRC_OFS_ADJUST: begin
                if (k_exit || !power_q) begin
                    next_ofs_state = src_pkg::SRC_OFS_IDLE;
                end else if (k_set) begin
                    next_ofs_state = src_pkg::SRC_OFS_DONE;
                end
            end
            src_pkg::SRC_OFS_DONE: begin
                // Back to the adjustment display after the flash
                if (flash_end) next_ofs_state = src_pkg::SRC_OFS_ADJUST;
            end
            default: next_ofs_state = src_pkg::SRC_OFS_IDLE;
        endcase
    end

    // Utility state and flash timer
    always_ff @(posedge clk) begin
        if (reset) begin
            ofs_state <= src_pkg::SRC_OFS_IDLE;
            flash_cnt <= 28'h0000000;
        end else begin
            ofs_state <= next_ofs_state;
            flash_cnt <= (next_ofs_state != ofs_state) ? 28'h0000000
                                                       : flash_cnt + 28'h0000001;
        end
    end

    // Offset steps live, so the applied value is the shown value
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_offset <= 16'h0000;
        end else if (step_ok && k_up && !k_down) begin
            ref_offset <= ref_offset + 16'h0001;
        end else if (step_ok && k_down && !k_up) begin
            ref_offset <= ref_offset - 16'h0001;
        end
    end

    // ==========================================================
    // Sample tick
    // ==========================================================
    logic [11:0] tick_cnt; // Divider to the control sample rate
    wire tick = (tick_cnt == 12'(`SRC_SAMPLE_CYC - 1));

    always_ff @(posedge clk) begin
        if (reset || tick) begin
            tick_cnt <= 12'h000;
        end else begin
            tick_cnt <= tick_cnt + 12'h001;
        end
    end

    // ==========================================================
    // Offset correction and scaling
    // ==========================================================
    // Scaled value wraps outside 16 bits; gain must keep it in range
    wire signed [16:0] cmd_corr = $signed({speed_cmd_in[15], speed_cmd_in})
                                + $signed({ref_offset[15], ref_offset});
    wire signed [33:0] cmd_prod = cmd_corr * $signed({1'b0, speed_input_gain});
    wire signed [15:0] cmd_rpm  = cmd_prod[23:8];
    wire [15:0] cmd_mag = cmd_rpm[15] ? 16'(-cmd_rpm) : cmd_rpm;

    // ==========================================================
    // Soft start ramp, Q16 rpm
    // ==========================================================
    logic signed [31:0] ramp;  // Ramp output
    wire signed [31:0] tgt = {cmd_rpm, 16'h0000};
    wire up_dir   = (tgt > ramp);
    // Accelerating means moving away from standstill
    wire accel    = up_dir ? (ramp >= 0) : (ramp <= 0);
    wire [15:0] t_ms = accel ? accel_ramp_time : decel_ramp_time;
    wire [31:0] t_smp = 32'(t_ms) * 32'(`SRC_MS_SAMPLES);
    wire [31:0] max_q = 32'(MAX_RPM) << 16;
    // Step is max speed over the set time, whatever the target
    wire [31:0] step  = (t_smp == 32'h0) ? 32'h0 : max_q / t_smp;
    wire signed [32:0] gap = 33'(tgt) - 33'(ramp);
    wire [32:0] gap_mag = gap[32] ? 33'(-gap) : gap;
    wire near_tgt = (gap_mag <= 33'(step)) || (t_ms == 16'h0000);

    // Constant-slope ramp updated once per sample
    always_ff @(posedge clk) begin
        if (reset) begin
            ramp <= 32'sh0;
        end else if (tick) begin
            if (near_tgt) begin
                ramp <= tgt;
            end else if (up_dir) begin
                ramp <= ramp + $signed(step);
            end else begin
                ramp <= ramp - $signed(step);
            end
        end
    end

    // ==========================================================
    // First-order lag filter, Q16 rpm
    // ==========================================================
    logic signed [31:0] filt;  // Filter state
    wire signed [32:0] fdiff = 33'(ramp) - 33'(filt);
    wire signed [17:0] fden  = $signed({2'b00, command_filter_time_constant})
                             + 18'sh1;
    wire signed [32:0] fstep = fdiff / fden; // Time constant in samples

    // Lag stage follows the ramp one sample later
    always_ff @(posedge clk) begin
        if (reset) begin
            filt <= 32'sh0;
        end else if (tick) begin
            filt <= filt + 32'(fstep);
        end
    end

    // ==========================================================
    // Zero clamp
    // ==========================================================
    logic signed [31:0] hold_pos; // Latched position
    wire method_a  = (control_method_select == `SRC_METHOD_CLAMP);
    // Factory allocation under method A reads the P input
    wire clamp_req = input_allocation_mode ? zcl_q : (method_a & prop_q);
    wire below     = (cmd_mag < clamp_speed_threshold);
    wire clamp_go  = clamp_req & below;
    wire signed [31:0] pos_err = hold_pos - $signed(position_count);
    wire [15:0] kp = gain_switch ? second_position_loop_gain
                                 : position_loop_gain;
    wire signed [48:0] hold_prod = pos_err * $signed({1'b0, kp});
    // Holding speed saturates so a large push cannot wrap sign
    wire sat_hi = (hold_prod > 49'sh7fff00);
    wire sat_lo = (hold_prod < -49'sh800000);
    wire [15:0] hold_rpm = sat_hi ? 16'h7fff
                         : sat_lo ? 16'h8000 : hold_prod[23:8];

    // Latch position on entry; hold loop drives back to it
    always_ff @(posedge clk) begin
        if (reset) begin
            clamp_active <= 1'b0;
            hold_pos     <= 32'sh0;
        end else begin
            clamp_active <= clamp_go;
            if (clamp_go && !clamp_active) begin
                hold_pos <= $signed(position_count);
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Clamp replaces the command by the position loop output
    always_ff @(posedge clk) begin
        if (reset) begin
            speed_ref_out <= 16'h0000;
        end else if (clamp_active) begin
            speed_ref_out <= hold_rpm;
        end else begin
            speed_ref_out <= filt[31:16];
        end
    end

    // Panel flags follow the utility state; the display always shows the offset
    always_ff @(posedge clk) begin
        if (reset) begin
            adjust_active  <= 1'b0;
            denied_flash   <= 1'b0;
            done_flash     <= 1'b0;
            offset_display <= 16'h0000;
        end else begin
            adjust_active  <= (next_ofs_state == src_pkg::SRC_OFS_ADJUST);
            denied_flash   <= (next_ofs_state == src_pkg::SRC_OFS_DENIED);
            done_flash     <= (next_ofs_state == src_pkg::SRC_OFS_DONE);
            offset_display <= ref_offset;
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    wire [31:0] status = {24'h000000, 1'b0, power_q, servo_q,
                          clamp_req, clamp_active, 1'b0, ofs_state};
    logic [31:0] rd_mux; // Selected read word

    always_comb begin
        case (address)
            `SRC_OFS_ACCEL:     rd_mux = {16'h0000, accel_ramp_time};
            `SRC_OFS_DECEL:     rd_mux = {16'h0000, decel_ramp_time};
            `SRC_OFS_FILT_TC:   rd_mux = {16'h0000, command_filter_time_constant};
            `SRC_OFS_CLAMP_LVL: rd_mux = {16'h0000, clamp_speed_threshold};
            `SRC_OFS_OFFSET:    rd_mux = {16'h0000, ref_offset};
            `SRC_OFS_CONFIG:    rd_mux = {27'h0000000, input_allocation_mode,
                                          control_method_select};
            `SRC_OFS_WPROT:     rd_mux = {16'h0000, write_protect_setting};
            `SRC_OFS_PGAIN1:    rd_mux = {16'h0000, position_loop_gain};
            `SRC_OFS_PGAIN2:    rd_mux = {16'h0000, second_position_loop_gain};
            `SRC_OFS_IN_GAIN:   rd_mux = {16'h0000, speed_input_gain};
            `SRC_OFS_STATUS:    rd_mux = status;
            `SRC_OFS_SPEED:     rd_mux = {16'h0000, speed_ref_out};
            default:            rd_mux = 32'h00000000; // Unmapped reads zero
        endcase
    end

    // Read data captured while waitrequest is still high
    always_ff @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h00000000;
        end else if (read && waitrequest) begin
            readdata <= rd_mux;
        end
    end

endmodule : src_conditioner

// >>> bench/src_chk_sva.sv
// Port-level assertions for the speed reference conditioner
`timescale 1ns/100ps
module src_chk (
    input wire logic        clk,                        // Drive clock
    input wire logic        reset,                      // Sync reset
    input wire logic        read,                       // Bus read
    input wire logic        write,                      // Bus write
    input wire logic        waitrequest,                // Bus stall
    input wire logic        main_power_on,              // Power pin
    input wire logic        proportional_control_input, // P pin
    input wire logic        clamp_request_input,        // Clamp pin
    input wire logic        clamp_active,               // Clamp holding
    input wire logic        adjust_active,              // Offset adjust
    input wire logic        denied_flash,               // Denial flash
    input wire logic        done_flash,                 // Completion flash
    input wire logic [15:0] offset_display              // Shown offset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Sequences
    sequence s_ack; !waitrequest ##1 waitrequest; endsequence
    sequence s_deny; (denied_flash && !adjust_active)[*8]; endsequence
    sequence s_pins_low; (!clamp_request_input && !proportional_control_input)[*8]; endsequence
    // ==========================================================
    // Properties
    property p_bus_ans; (read || write) && waitrequest |=> s_ack; endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
    property p_deny_noadj; denied_flash |-> !adjust_active; endproperty
    a_deny_noadj: assert property (p_deny_noadj) else $error("adjust while denied");
    property p_deny_hold; $rose(denied_flash) |-> s_deny; endproperty
    a_deny_hold: assert property (p_deny_hold) else $error("denial flash short");
    property p_adj_pow; $rose(adjust_active) |-> $past(main_power_on); endproperty
    a_adj_pow: assert property (p_adj_pow) else $error("adjust without power");
    property p_ofs_step;
        adjust_active && $past(adjust_active) && $changed(offset_display)
            |-> 16'(offset_display - $past(offset_display)) inside {16'h0001, 16'hffff};
    endproperty
    a_ofs_step: assert property (p_ofs_step) else $error("offset step not one");
    property p_done_adj; $rose(done_flash) |-> $past(adjust_active); endproperty
    a_done_adj: assert property (p_done_adj) else $error("done outside adjust");
    property p_done_back; $fell(done_flash) |-> ##[0:1] adjust_active; endproperty
    a_done_back: assert property (p_done_back) else $error("no return to adjust");
    property p_clamp_drop; s_pins_low |-> !clamp_active; endproperty
    a_clamp_drop: assert property (p_clamp_drop) else $error("clamp without request");
endmodule : src_chk

bind src_conditioner src_chk u_chk (
    .clk, .reset, .read, .write, .waitrequest, .main_power_on, .proportional_control_input,
    .clamp_request_input, .clamp_active, .adjust_active, .denied_flash, .done_flash,
    .offset_display);

// >>> bench/src_host.sv
// Host controller model: command, shaft position and pins
`timescale 1ns/100ps
module src_host (
    input  wire logic        clk,             // Drive clock
    input  wire logic [15:0] cmd,             // Command wanted
    input  wire logic [31:0] pos,             // Shaft position wanted
    input  wire logic [4:0]  pins,            // Pin levels wanted
    output logic      [15:0] speed_cmd_in = 16'h0000,   // Command code
    output logic      [31:0] position_count = 32'h0000, // Encoder count
    output logic      [4:0]  pin_out = 5'h00            // Pin levels
);
    // Outputs move just after an edge
    always @(posedge clk) begin
        speed_cmd_in   <= cmd;
        position_count <= pos;
        pin_out        <= pins;
    end
endmodule : src_host

// >>> bench/src_conditioner_bench.sv
// Self-checking bench for the speed reference conditioner
`timescale 1ns/100ps
`include "src_defs.svh"
module src_conditioner_bench;
    logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0, rd, lfsr = 32'h257c0588, h_pos = 32'h0, readdata, pc;
    logic [15:0] h_cmd = 16'h0, sc, speed_ref_out, offset_display;
    logic [4:0]  h_pins = 5'h00, pins; // {gain, power, servo, p, clamp}
    logic        waitrequest, clamp_active, adjust_active, denied_flash, done_flash;
    int          n_errors = 0, compares = 0, ofs = 0, m [0:15];
    always #2 clk = ~clk;
    src_host host (.clk(clk), .cmd(h_cmd), .pos(h_pos), .pins(h_pins),
        .speed_cmd_in(sc), .position_count(pc), .pin_out(pins));
    src_conditioner #(.FLASH_CYC(50)) uut (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .speed_cmd_in(sc), .position_count(pc),
        .gain_switch(pins[4]), .main_power_on(pins[3]), .servo_on(pins[2]),
        .proportional_control_input(pins[1]), .clamp_request_input(pins[0]),
        .speed_ref_out(speed_ref_out), .clamp_active(clamp_active),
        .adjust_active(adjust_active), .denied_flash(denied_flash),
        .done_flash(done_flash), .offset_display(offset_display));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] next_rand(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; the model follows writable registers
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        read <= !w; write <= w; address <= a; writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        if (w && a < 8'h28 && a != 8'h10) m[a[5:2]] = d;
        read <= 1'b0; write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(logic [7:0] a); bus(1'b0, a, 32'h0); chk(rd, 32'(m[a[5:2]])); endtask : rchk
    task automatic wt(int n); repeat (n) @(posedge clk); endtask : wt
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    initial begin wt(80000); n_errors++; complete_run(); end
    // ==========================================================
    // Main sequence
    initial begin
        m = '{default: 0};
        m[2] = 40; m[3] = 10;
        m[7] = `SRC_RST_PGAIN; m[8] = `SRC_RST_PGAIN; m[9] = `SRC_RST_IN_GAIN; m[10] = 32'h60;
        wt(8); reset <= 1'b0; h_pins <= 5'b01100; wt(1);
        for (int a = 0; a < 16; a++) rchk(8'(a * 4));
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            bus(1'b1, 8'h00, 32'(lfsr[15:0] % 16'd10001)); rchk(8'h00);
        end
        bus(1'b1, 8'h10, 32'h1234); rchk(8'h10);
        // Write protected entry is refused with a flash
        bus(1'b1, 8'h18, 32'h1); bus(1'b1, 8'h30, 32'h2); wt(2);
        chk(denied_flash, 1); chk(adjust_active, 0);
        wt(60); chk(denied_flash, 0); chk(adjust_active, 0);
        bus(1'b1, 8'h18, 32'h0); bus(1'b1, 8'h30, 32'h2); wt(2); chk(adjust_active, 1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h30, i < 3 ? 32'h4 : 32'h8); ofs += i < 3 ? 1 : -1;
        end
        wt(2); m[4] = ofs; chk(offset_display, 32'(ofs)); rchk(8'h10);
        bus(1'b1, 8'h30, 32'h10); wt(2); chk(done_flash, 1);
        wt(60); chk(done_flash, 0); chk(adjust_active, 1);
        bus(1'b1, 8'h30, 32'h20); bus(1'b1, 8'h30, 32'h1); m[0] = 0;
        rchk(8'h00); rchk(8'h10);
        // Pass-through with ramp times and filter lag zero, then a 1 ms accel ramp
        bus(1'b1, 8'h08, 32'h0); lfsr = next_rand(lfsr); h_cmd <= {6'h0, lfsr[9:0]};
        wt(7600); chk(speed_ref_out, 16'({6'h0, lfsr[9:0]} + ofs));
        h_cmd <= 16'(-ofs); wt(2600); bus(1'b1, 8'h00, 32'h1); h_cmd <= 16'(600 - ofs);
        wt(12500); chk(speed_ref_out, 16'd240);
        wt(25000); chk(speed_ref_out, 16'd600);
        // Zero clamp: dedicated input, then P input in method A
        bus(1'b1, 8'h00, 32'h0); h_cmd <= 16'(-ofs); h_pos <= 32'd100;
        bus(1'b1, 8'h14, 32'h10); h_pins <= 5'b01101; wt(2600);
        chk(clamp_active, 1); chk(speed_ref_out, 16'h0000);
        h_pos <= 32'd104; wt(2600); chk(speed_ref_out, 16'hfffc);
        bus(1'b1, 8'h20, 32'h200); h_pins <= 5'b11101; wt(2600);
        chk(speed_ref_out, 16'hfff8);
        h_pins <= 5'b01100; wt(12); chk(clamp_active, 0);
        bus(1'b1, 8'h14, 32'ha); h_pins <= 5'b01110; wt(20); chk(clamp_active, 1);
        h_cmd <= 16'd500; wt(20); chk(clamp_active, 0);
        complete_run();
    end
endmodule : src_conditioner_bench
